//--- rtl/sso_pkg.sv
// Purpose: constants and types for the sync status overhead adaptation block
// Assumes: one clock, frame strobes come from logic on that clock
// Notes: register map is reached over ahb-lite, one word per register
package sso_pkg;
	localparam int CS_W = 8;

	typedef enum logic [2:0] {
		QL_PRC,
		QL_SSUT,
		QL_SSUL,
		QL_SEC,
		QL_DNU,
		QUALITY_NOT_SUPPORTED
	} sso_ql_type;

	localparam logic [3:0] SSM_PRC  = 4'h2;
	localparam logic [3:0] SSM_SSUT = 4'h4;
	localparam logic [3:0] SSM_SSUL = 4'h8;
	localparam logic [3:0] SSM_SEC  = 4'hb;
	localparam logic [3:0] SSM_DNU  = 4'hf;
	localparam logic       TM_PRC   = 1'h0;
	localparam logic       TM_OTHER = 1'h1;

	// persistence of the receive filter, in frames
	localparam logic [1:0] FILTER_FRAMES = 2'h3;
	// frames of 125 us in one 500 us multiframe
	localparam int         MF_PERIOD_US  = 500;
	localparam logic [1:0] MF_LAST_PHASE = 2'h3;

	// register map, byte addresses
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_CSID   = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;

	// ctrl field positions
	localparam int CTRL_QEN_BIT  = 0;
	localparam int CTRL_RSUP_BIT = 1;
	localparam int CTRL_TSUP_BIT = 2;
	localparam int CTRL_TM_BIT   = 3;
	// status field positions
	localparam int STAT_CODE_LSB  = 0;
	localparam int STAT_QL_LSB    = 4;
	localparam int STAT_PHASE_LSB = 8;

	// reset values
	localparam logic [3:0]      CTRL_RST = 4'h0;
	localparam logic [CS_W-1:0] CSID_RST = 8'h00;

	typedef struct packed {
		logic tm;
		logic tsup;
		logic rsup;
		logic qen;
	} sso_cfg_type;

	typedef struct packed {
		logic [3:0] last;
		logic [1:0] cnt;
		logic [3:0] accepted;
	} sso_flt_state_type;
endpackage

//--- rtl/sso_filter.sv
// Purpose: three-frame persistence filter for the received status nibble
// Assumes: frame_start is a one-cycle pulse on hclk
// Notes: accepted code holds while nothing new persists
`timescale 1ns/100ps
module sso_filter (
	input  wire logic       hclk,        // system clock
	input  wire logic       hresetn,     // async reset, active low
	input  wire logic       enable,      // filtering allowed
	input  wire logic       frame_start, // one pulse per frame
	input  wire logic [3:0] code_in,     // received nibble
	output logic      [3:0] accepted     // last accepted nibble
);
	sso_pkg::sso_flt_state_type st_ff;
	sso_pkg::sso_flt_state_type nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (!enable) begin
			nxt_st.cnt = 2'h0;
		end else if (frame_start) begin
			if (st_ff.cnt != 2'h0 && code_in == st_ff.last) begin
				if (st_ff.cnt != sso_pkg::FILTER_FRAMES) begin
					nxt_st.cnt = st_ff.cnt + 2'h1;
				end
				if (st_ff.cnt == sso_pkg::FILTER_FRAMES - 2'h1) begin
					nxt_st.accepted = code_in;
				end
			end else begin
				nxt_st.last = code_in;
				nxt_st.cnt  = 2'h1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff          <= '0;
			st_ff.accepted <= sso_pkg::SSM_DNU;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign accepted = st_ff.accepted;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_third_frame;
		enable && frame_start && st_ff.cnt == 2'h2 && code_in == st_ff.last;
	endsequence

	property p_accept_third;
		logic [3:0] c;
		(s_third_frame, c = code_in) |=> accepted == c;
	endproperty
	a_accept_third: assert property (p_accept_third) else $error("code not accepted");

	property p_hold_on_change;
		enable && frame_start && code_in != st_ff.last |=> $stable(accepted);
	endproperty
	a_hold_on_change: assert property (p_hold_on_change) else $error("early accept");
endmodule

//--- rtl/sso_top.sv
// Purpose: sync status overhead adaptation, source and sink directions
// Assumes: frame strobes and bytes come from transport logic on hclk
// Notes: recovered timing arrives from outside and is resynchronised
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
module sso_top (
	input  wire logic                    hclk,                   // system clock, 50 MHz
	input  wire logic                    hresetn,                // async reset, active low
	input  wire logic                    hsel,                   // ahb select
	input  wire logic [11:0]             haddr,                  // ahb address
	input  wire logic [1:0]              htrans,                 // ahb transfer type
	input  wire logic                    hwrite,                 // ahb write
	input  wire logic [2:0]              hsize,                  // ahb size
	input  wire logic [31:0]             hwdata,                 // ahb write data
	input  wire logic                    hready,                 // ahb bus ready
	output logic                         hreadyout,              // ahb slave ready
	output logic                         hresp,                  // ahb response
	output logic      [31:0]             hrdata,                 // ahb read data
	input  wire logic                    rx_frame_start,         // sink frame pulse
	input  wire logic [7:0]              rx_section_sync_byte,   // received sync byte
	input  wire logic                    trail_signal_fail_in,   // incoming trail fail
	input  wire logic                    rx_timing_in,           // recovered timing pin
	output logic                         sync_clock_out,         // forwarded timing
	output logic                         server_fail_out,        // server signal fail
	output logic      [sso_pkg::CS_W-1:0] forward_clock_source,  // sink clock source
	output logic      [sso_pkg::CS_W-1:0] remote_clock_source,   // to paired source
	output sso_pkg::sso_ql_type          quality_level_out,      // sink quality level
	input  wire logic                    tx_frame_start,         // source frame pulse
	input  wire logic                    multiframe_start_in,    // path multiframe start
	input  wire sso_pkg::sso_ql_type     quality_level_port,     // source quality level
	input  wire logic [sso_pkg::CS_W-1:0] tx_clock_source,       // source clock id
	input  wire logic [sso_pkg::CS_W-1:0] remote_clock_source_in, // from paired sink
	input  wire logic [7:0]              tx_section_byte_in,     // byte before insertion
	input  wire logic [7:0]              tx_path_byte_in,        // path byte before insertion
	output logic      [7:0]              section_sync_byte,      // byte with code inserted
	output logic      [7:0]              path_maintenance_byte   // path byte with code
);
	typedef struct packed {
		sso_pkg::sso_cfg_type    cfg;
		logic [sso_pkg::CS_W-1:0] csid;
		logic                    wr_pend;
		logic [11:0]             wr_addr;
		logic                    hreadyout;
		logic [31:0]             hrdata;
		logic                    tim_s1;
		logic                    tim_s2;
		logic                    tim_s3;
		logic                    sync_clk;
		logic                    ssf;
		logic [sso_pkg::CS_W-1:0] fwd_cs;
		logic [sso_pkg::CS_W-1:0] rem_cs;
		sso_pkg::sso_ql_type     ql_out;
		logic [7:0]              sec_byte;
		logic [7:0]              path_byte;
		logic [1:0]              phase;
		logic [3:0]              path_code;
	} sso_top_state_type;

	sso_top_state_type st_ff;
	sso_top_state_type nxt_st;
	logic [3:0]        rx_accepted;
	logic              loop_or_sup;
	logic [3:0]        tx_code;
	logic              tx_marker;
	logic              addr_ok;
	logic [31:0]       rd_word;

	////////////////////////////////////////////////////////////////////////////////
	// code tables

	function automatic logic [3:0] ql_to_ssm(input sso_pkg::sso_ql_type ql);
		case (ql)
			sso_pkg::QL_PRC:  ql_to_ssm = sso_pkg::SSM_PRC;
			sso_pkg::QL_SSUT: ql_to_ssm = sso_pkg::SSM_SSUT;
			sso_pkg::QL_SSUL: ql_to_ssm = sso_pkg::SSM_SSUL;
			sso_pkg::QL_SEC:  ql_to_ssm = sso_pkg::SSM_SEC;
			default:          ql_to_ssm = sso_pkg::SSM_DNU;
		endcase
	endfunction

	function automatic sso_pkg::sso_ql_type ssm_to_ql(input logic [3:0] code);
		case (code)
			sso_pkg::SSM_PRC:  ssm_to_ql = sso_pkg::QL_PRC;
			sso_pkg::SSM_SSUT: ssm_to_ql = sso_pkg::QL_SSUT;
			sso_pkg::SSM_SSUL: ssm_to_ql = sso_pkg::QL_SSUL;
			sso_pkg::SSM_SEC:  ssm_to_ql = sso_pkg::QL_SEC;
			// unlisted codes are treated as do-not-use
			default:           ssm_to_ql = sso_pkg::QL_DNU;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// sink filter

	sso_filter u_filter (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.enable      (st_ff.cfg.qen && st_ff.cfg.rsup),
		.frame_start (rx_frame_start),
		.code_in     (rx_section_sync_byte[3:0]),
		.accepted    (rx_accepted)
	);

	////////////////////////////////////////////////////////////////////////////////
	// source code selection

	always_comb begin
		loop_or_sup = (remote_clock_source_in == tx_clock_source) || st_ff.cfg.tsup;
		if (!st_ff.cfg.qen) begin
			tx_code   = sso_pkg::SSM_DNU;
			tx_marker = sso_pkg::TM_OTHER;
		end else if (loop_or_sup) begin
			tx_code   = sso_pkg::SSM_DNU;
			tx_marker = sso_pkg::TM_OTHER;
		end else begin
			tx_code   = ql_to_ssm(quality_level_port);
			// unknown levels also give marker 1
			tx_marker = (quality_level_port == sso_pkg::QL_PRC) ? sso_pkg::TM_PRC
			                                                   : sso_pkg::TM_OTHER;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register read mux

	always_comb begin
		addr_ok = 1'b1;
		rd_word = 32'h0000_0000;
		case (haddr)
			sso_pkg::OFS_CTRL:   rd_word[3:0] = st_ff.cfg;
			sso_pkg::OFS_CSID:   rd_word[sso_pkg::CS_W-1:0] = st_ff.csid;
			sso_pkg::OFS_STATUS: begin
				rd_word[sso_pkg::STAT_CODE_LSB +: 4]  = rx_accepted;
				rd_word[sso_pkg::STAT_QL_LSB +: 3]    = st_ff.ql_out;
				rd_word[sso_pkg::STAT_PHASE_LSB +: 2] = st_ff.phase;
			end
			default:             addr_ok = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		nxt_st           = st_ff;
		nxt_st.hreadyout = 1'b1;
		// bus: zero wait states, read data captured in the address phase
		nxt_st.wr_pend = hsel && htrans[1] && hready && hwrite;
		if (hsel && htrans[1] && hready) begin
			nxt_st.wr_addr = haddr;
			if (!hwrite) begin
				nxt_st.hrdata = addr_ok ? rd_word : 32'h0000_0000;
			end
		end
		if (st_ff.wr_pend) begin
			case (st_ff.wr_addr)
				sso_pkg::OFS_CTRL: nxt_st.cfg  = hwdata[3:0];
				sso_pkg::OFS_CSID: nxt_st.csid = hwdata[sso_pkg::CS_W-1:0];
				default:           nxt_st.cfg  = st_ff.cfg;
			endcase
		end

		// timing pin: change passes once stages two and three agree
		nxt_st.tim_s1 = rx_timing_in;
		nxt_st.tim_s2 = st_ff.tim_s1;
		nxt_st.tim_s3 = st_ff.tim_s2;
		if (st_ff.tim_s2 == st_ff.tim_s3) begin
			nxt_st.sync_clk = st_ff.tim_s3;
		end

		// sink outputs
		nxt_st.ssf    = trail_signal_fail_in;
		nxt_st.fwd_cs = st_ff.csid;
		nxt_st.rem_cs = st_ff.csid;
		if (st_ff.cfg.qen && st_ff.cfg.rsup) begin
			nxt_st.ql_out = ssm_to_ql(rx_accepted);
		end else begin
			nxt_st.ql_out = sso_pkg::QUALITY_NOT_SUPPORTED;
		end

		// source outputs, updated once per frame
		if (tx_frame_start) begin
			nxt_st.sec_byte = {tx_section_byte_in[7:4], tx_code};

			// multiframe phase restarts on the shared start pulse
			nxt_st.phase = multiframe_start_in ? 2'h0 : st_ff.phase + 2'h1;
			if (nxt_st.phase == 2'h0) begin
				// code latched once so a multiframe never mixes two codes
				nxt_st.path_code = tx_code;
			end
			nxt_st.path_byte = tx_path_byte_in;
			if (st_ff.cfg.tm) begin
				nxt_st.path_byte[0] = tx_marker;
			end else begin
				nxt_st.path_byte[2:1] = nxt_st.phase;
				nxt_st.path_byte[0]   = nxt_st.path_code[sso_pkg::MF_LAST_PHASE - nxt_st.phase];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff           <= '0;
			st_ff.cfg       <= sso_pkg::CTRL_RST;
			st_ff.csid      <= sso_pkg::CSID_RST;
			st_ff.hreadyout <= 1'b1;
			st_ff.ql_out    <= sso_pkg::QL_DNU;
			st_ff.path_code <= sso_pkg::SSM_DNU;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign hreadyout             = st_ff.hreadyout;
	assign hresp                 = 1'b0;
	assign hrdata                = st_ff.hrdata;
	assign sync_clock_out        = st_ff.sync_clk;
	assign server_fail_out       = st_ff.ssf;
	assign forward_clock_source  = st_ff.fwd_cs;
	assign remote_clock_source   = st_ff.rem_cs;
	assign quality_level_out     = st_ff.ql_out;
	assign section_sync_byte     = st_ff.sec_byte;
	assign path_maintenance_byte = st_ff.path_byte;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_nsupp;
		!(st_ff.cfg.qen && st_ff.cfg.rsup) |=> quality_level_out == sso_pkg::QUALITY_NOT_SUPPORTED;
	endproperty
	a_nsupp: assert property (p_nsupp) else $error("not-supported not forced");

	property p_cs_copy;
		1'b1 |=> forward_clock_source == $past(st_ff.csid)
		      && remote_clock_source == $past(st_ff.csid);
	endproperty
	a_cs_copy: assert property (p_cs_copy) else $error("clock source id not copied");

	property p_ssf;
		trail_signal_fail_in |=> server_fail_out;
	endproperty
	a_ssf: assert property (p_ssf) else $error("server fail not forwarded");

	sequence s_tx_frame_disabled;
		tx_frame_start && !st_ff.cfg.qen;
	endsequence

	property p_src_disabled;
		s_tx_frame_disabled |=> section_sync_byte[3:0] == sso_pkg::SSM_DNU;
	endproperty
	a_src_disabled: assert property (p_src_disabled) else $error("disabled code wrong");

	property p_src_loop;
		tx_frame_start && remote_clock_source_in == tx_clock_source
		|=> section_sync_byte[3:0] == sso_pkg::SSM_DNU;
	endproperty
	a_src_loop: assert property (p_src_loop) else $error("timing loop code not ones");

	property p_src_prc;
		tx_frame_start && st_ff.cfg.qen && !st_ff.cfg.tsup
		&& remote_clock_source_in != tx_clock_source
		&& quality_level_port == sso_pkg::QL_PRC
		|=> section_sync_byte[3:0] == sso_pkg::SSM_PRC;
	endproperty
	a_src_prc: assert property (p_src_prc) else $error("primary code wrong");

	property p_marker_prc;
		tx_frame_start && st_ff.cfg.tm && st_ff.cfg.qen && !st_ff.cfg.tsup
		&& remote_clock_source_in != tx_clock_source
		&& quality_level_port == sso_pkg::QL_PRC
		|=> path_maintenance_byte[0] == sso_pkg::TM_PRC;
	endproperty
	a_marker_prc: assert property (p_marker_prc) else $error("marker not 0");

	property p_mf_start;
		tx_frame_start && multiframe_start_in && !st_ff.cfg.tm
		|=> path_maintenance_byte[2:1] == 2'h0
		 && path_maintenance_byte[0] == $past(tx_code[3]);
	endproperty
	a_mf_start: assert property (p_mf_start) else $error("multiframe start wrong");

	property p_src_sup;
		tx_frame_start && st_ff.cfg.tsup
		|=> section_sync_byte[3:0] == sso_pkg::SSM_DNU;
	endproperty
	a_src_sup: assert property (p_src_sup) else $error("suppressed code not ones");

	property p_rsup_off;
		!st_ff.cfg.rsup |=> quality_level_out == sso_pkg::QUALITY_NOT_SUPPORTED;
	endproperty
	a_rsup_off: assert property (p_rsup_off) else $error("support off not forced");

	property p_ql_prc;
		st_ff.cfg.qen && st_ff.cfg.rsup && rx_accepted == sso_pkg::SSM_PRC
		|=> quality_level_out == sso_pkg::QL_PRC;
	endproperty
	a_ql_prc: assert property (p_ql_prc) else $error("accepted code not mapped");

	property p_sec_upper;
		tx_frame_start |=> section_sync_byte[7:4] == $past(tx_section_byte_in[7:4]);
	endproperty
	a_sec_upper: assert property (p_sec_upper) else $error("upper bits disturbed");

	// section byte only moves on a frame pulse
	property p_sec_hold;
		!tx_frame_start |=> $stable(section_sync_byte);
	endproperty
	a_sec_hold: assert property (p_sec_hold) else $error("section byte moved");

	property p_tm_forced;
		tx_frame_start && st_ff.cfg.tm && (!st_ff.cfg.qen || st_ff.cfg.tsup)
		|=> path_maintenance_byte[0] == sso_pkg::TM_OTHER;
	endproperty
	a_tm_forced: assert property (p_tm_forced) else $error("marker not forced");

	property p_unknown_level;
		tx_frame_start
		&& (quality_level_port == sso_pkg::QL_DNU || quality_level_port == sso_pkg::QUALITY_NOT_SUPPORTED)
		|=> section_sync_byte[3:0] == sso_pkg::SSM_DNU;
	endproperty
	a_unknown_level: assert property (p_unknown_level) else $error("unknown level code");

	property p_phase_step;
		tx_frame_start && !multiframe_start_in && !st_ff.cfg.tm
		|=> path_maintenance_byte[2:1] == $past(st_ff.phase) + 2'h1;
	endproperty
	a_phase_step: assert property (p_phase_step) else $error("indicator not stepped");

	sequence s_timing_steady;
		$stable(rx_timing_in) [*5];
	endsequence

	property p_sync_follow;
		s_timing_steady |=> sync_clock_out == $past(rx_timing_in);
	endproperty
	a_sync_follow: assert property (p_sync_follow) else $error("timing not forwarded");

	property p_ssf_low;
		!trail_signal_fail_in |=> !server_fail_out;
	endproperty
	a_ssf_low: assert property (p_ssf_low) else $error("server fail stuck");
endmodule

//--- dv/sso_frame_model.sv
// Purpose: transport side model making frame and multiframe strobes
// Assumes: strobes change by non-blocking assignment after the rising edge
// Notes: sink and source frames are offset so both directions stay busy
`timescale 1ns/100ps
module sso_frame_model #(
	parameter int FRAME_CYC = 10
) (
	input  wire logic hclk,     // system clock
	input  wire logic hresetn,  // async reset, active low
	output logic      rx_frame, // sink frame pulse
	output logic      tx_frame, // source frame pulse
	output logic      mf_start  // first frame of multiframe
);
	int         cyc;
	logic [1:0] frm;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc <= 0;
			frm <= 2'h0;
			rx_frame <= 1'b0;
			tx_frame <= 1'b0;
			mf_start <= 1'b0;
		end else begin
			cyc <= (cyc == FRAME_CYC - 1) ? 0 : cyc + 1;
			if (cyc == FRAME_CYC - 1) begin
				frm <= frm + 2'h1;
			end
			rx_frame <= (cyc == 3);
			tx_frame <= (cyc == 0);
			// inverted off-frame, so a stray sample is not silently right
			mf_start <= (cyc == 0) ~^ (frm == 2'h0);
		end
	end
endmodule

//--- dv/sync_status_overhead_adaptation_test.sv
// Purpose: self-checking bench for the sync status overhead block
// Assumes: one bus slave, frame strobes from the frame model
// Notes: outputs are read just after an edge, before that edge's updates land
`timescale 1ns/100ps
module sync_status_overhead_adaptation_test;
	logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [1:0]          htrans;
	logic [2:0]          hsize;
	logic [11:0]         haddr;
	logic [31:0]         hwdata, hrdata, rd;
	logic                rx_fs, tsf, rx_tim, sclk, ssf, tx_fs, mfs;
	logic [7:0]          rx_b, fcs, rcs, tx_cs, rcs_in, sec_in, path_in, sec_o, path_o;
	sso_pkg::sso_ql_type qlo, qli;
	int                  failures, cmp_count, seed, r, i, j;
	logic [3:0]          c, cd, last, acc, cfg;
	logic [1:0]          cnt;

	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	sso_frame_model i_sso_frame_model (.hclk(hclk), .hresetn(hresetn), .rx_frame(rx_fs),
		.tx_frame(tx_fs), .mf_start(mfs));

	sso_top i_sso_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.rx_frame_start(rx_fs), .rx_section_sync_byte(rx_b), .trail_signal_fail_in(tsf),
		.rx_timing_in(rx_tim), .sync_clock_out(sclk), .server_fail_out(ssf),
		.forward_clock_source(fcs), .remote_clock_source(rcs), .quality_level_out(qlo),
		.tx_frame_start(tx_fs), .multiframe_start_in(mfs), .quality_level_port(qli),
		.tx_clock_source(tx_cs), .remote_clock_source_in(rcs_in),
		.tx_section_byte_in(sec_in), .tx_path_byte_in(path_in),
		.section_sync_byte(sec_o), .path_maintenance_byte(path_o));

	////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task tick(input int k);
		repeat (k) @(posedge hclk);
	endtask

	// w: 0 bus ready, 1 source frame, 2 sink frame
	task automatic wt(input int w);
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while ((w == 0 ? hreadyout : w == 1 ? tx_fs : rx_fs) !== 1'b1 && k < 60);
		if (k >= 60) begin
			failures++;
			$display("[FAIL] wait %0d timed out", w);
			final_report();
		end
	endtask

	task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wt(0);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wt(0);
		rd = hrdata;
	endtask

	// g is {tm,tsup,rsup,qen}
	function automatic logic [3:0] f_code(sso_pkg::sso_ql_type q, logic [3:0] g);
		if (!g[0] || g[2] || rcs_in == tx_cs) return 4'hf;
		case (q)
			sso_pkg::QL_PRC:  return 4'h2;
			sso_pkg::QL_SSUT: return 4'h4;
			sso_pkg::QL_SSUL: return 4'h8;
			sso_pkg::QL_SEC:  return 4'hb;
			default:          return 4'hf;
		endcase
	endfunction

	function automatic sso_pkg::sso_ql_type f_ql(logic [3:0] v);
		case (v)
			4'h2:    return sso_pkg::QL_PRC;
			4'h4:    return sso_pkg::QL_SSUT;
			4'h8:    return sso_pkg::QL_SSUL;
			4'hb:    return sso_pkg::QL_SEC;
			default: return sso_pkg::QL_DNU;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 74717;
		failures = 0;
		cmp_count = 0;
		hresetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		{rx_b, tsf, rx_tim, tx_cs, rcs_in, sec_in, path_in} = '0;
		qli = sso_pkg::QL_PRC;
		tick(8);
		hresetn <= 1'b1;
		tick(1);
		bus(1'b0, sso_pkg::OFS_CTRL, 32'h0);
		chk("ctrl reset", rd, 32'h0);
		bus(1'b0, sso_pkg::OFS_CSID, 32'h0);
		chk("csid reset", rd, 32'h0);
		bus(1'b0, sso_pkg::OFS_STATUS, 32'h0);
		chk("accepted reset", 32'(rd[3:0]), 32'hf);
		bus(1'b1, 12'h00c, 32'hffffffff);
		bus(1'b0, 12'h00c, 32'h0);
		chk("unmapped", rd, 32'h0);
		chk("ql disabled", 32'(qlo), 32'(sso_pkg::QUALITY_NOT_SUPPORTED));
		$display("reset test done");
		for (i = 0; i < 8; i++) begin
			r = $random(seed);
			bus(1'b1, sso_pkg::OFS_CSID, 32'(r[7:0]));
			tsf <= r[8];
			rx_tim <= r[9];
			tick(2);
			chk("forward cs", 32'(fcs), 32'(r[7:0]));
			chk("remote cs", 32'(rcs), 32'(r[7:0]));
			chk("server fail", 32'(ssf), 32'(r[8]));
			tick(3);
			chk("sync clock", 32'(sclk), 32'(r[9]));
		end
		$display("pass-through test done");
		// first six runs are clean so the plain mapping is seen per level
		for (i = 0; i < 24; i++) begin
			r = $random(seed);
			qli <= sso_pkg::sso_ql_type'(3'(i % 6));
			tx_cs <= r[7:0];
			rcs_in <= (i >= 6 && r[9:8] == 2'h0) ? r[7:0] : ~r[7:0];
			sec_in <= r[23:16];
			path_in <= r[31:24];
			cfg = i < 6 ? {r[10], 3'h1} : {r[10], r[11], 1'b0, r[12]};
			bus(1'b1, sso_pkg::OFS_CTRL, 32'(cfg));
			j = 0;
			do begin
				wt(1);
				j++;
			end while (mfs !== 1'b1 && j < 8);
			if (mfs !== 1'b1) begin
				failures++;
				$display("[FAIL] multiframe start never seen");
				final_report();
			end
			c = f_code(qli, cfg);
			for (j = 0; j < 4; j++) begin
				tick(1);
				chk("section byte", 32'(sec_o), 32'({sec_in[7:4], c}));
				chk("path byte", 32'(path_o), 32'(cfg[3] ? {path_in[7:1], c != 4'h2} :
					{path_in[7:3], 2'(j), c[3 - j]}));
				if (j < 3) wt(1);
			end
		end
		$display("source test done");
		bus(1'b1, sso_pkg::OFS_CTRL, 32'h3);
		acc = 4'hf;
		cnt = 2'h0;
		last = 4'h0;
		for (i = 0; i < 20; i++) begin
			r = $random(seed);
			cd = r[2] ? r[7:4] : r[1:0] == 0 ? 4'h2 : r[1:0] == 1 ? 4'h4 :
				r[1:0] == 2 ? 4'h8 : 4'hb;
			for (j = 0; j <= r[9:8]; j++) begin
				rx_b <= {r[15:12], cd};
				wt(2);
				if (cnt == 0 || cd != last) cnt = 2'h1;
				else if (cnt < 3) cnt++;
				last = cd;
				if (cnt == 3) acc = cd;
				tick(2);
				chk("sink ql", 32'(qlo), 32'(f_ql(acc)));
			end
		end
		bus(1'b0, sso_pkg::OFS_STATUS, 32'h0);
		chk("status code", 32'(rd[3:0]), 32'(acc));
		chk("status ql", 32'(rd[6:4]), 32'(f_ql(acc)));
		$display("sink filter test done");
		// received codes must be ignored while handling or support is off
		for (i = 0; i < 2; i++) begin
			bus(1'b1, sso_pkg::OFS_CTRL, i == 0 ? 32'h1 : 32'h2);
			rx_b <= {4'h0, ~acc};
			repeat (3) wt(2);
			tick(2);
			chk("ql forced", 32'(qlo), 32'(sso_pkg::QUALITY_NOT_SUPPORTED));
			bus(1'b0, sso_pkg::OFS_STATUS, 32'h0);
			chk("code kept", 32'(rd[3:0]), 32'(acc));
		end
		$display("sink disable test done");
		final_report();
	end
endmodule
